// file: rtl/eps_pkg.sv
// Constants for the field-programmable ROM programming sequencer.
// Assumes a single 50 MHz system clock; all waits are counted in its cycles.
package eps_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned WORDS     = 256;

	// ---------------------------------------------------------------
	// Clock and times in their own units
	// ---------------------------------------------------------------
	localparam int unsigned CLK_NS        = 20;
	localparam int unsigned SETTLE_NS     = 1000;      // Address/data settle before supplies
	localparam int unsigned O_LEAD_NS     = 1000;      // Supplies before program pulse
	localparam int unsigned O_LAG_NS      = 1000;      // Supplies after program pulse
	localparam int unsigned O_PULSE_MS    = 20;
	localparam int unsigned O_PERIOD_MS   = 1000;
	localparam int unsigned O_PULSES      = 5;
	localparam int unsigned I_COMP_US     = 25;        // Complement address under power
	localparam int unsigned I_PWR_US      = 100;       // Power on before program pulse
	localparam int unsigned I_TRUE_US     = 10;        // True address before program pulse
	localparam int unsigned I_PULSE_MS    = 3;
	localparam int unsigned I_LAG_MIN_US  = 10;        // Supplies off 10..100 us after pulse
	localparam int unsigned I_OFF_MS      = 13;        // Power-off time keeps duty below 20 %
	localparam int unsigned I_PASSES      = 32;
	localparam int unsigned READ_NS       = 2000;      // Read access wait in verify

	// ---------------------------------------------------------------
	// Cycle counts, least times rounded up
	// ---------------------------------------------------------------
	localparam int unsigned SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned O_LEAD_CYC  = (O_LEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned O_LAG_CYC   = (O_LAG_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned I_COMP_CYC  = (I_COMP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned I_TRUE_CYC  = (I_TRUE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned I_REST_CYC  = ((I_PWR_US - I_COMP_US) * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned I_LAG_CYC   = (I_LAG_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned READ_CYC    = (READ_NS + CLK_NS - 1) / CLK_NS;
	// Long counts, used as top-level parameter defaults
	localparam int unsigned O_PULSE_CYC = O_PULSE_MS * 1000000 / CLK_NS;
	// Supplies stay on through lead, pulse and lag; the period is stretched
	// where needed so that this on time never exceeds the allowed duty share
	localparam int unsigned O_DUTY_PCT  = 2;
	localparam int unsigned O_ON_CYC    = O_LEAD_CYC + O_PULSE_CYC + O_LAG_CYC;
	localparam int unsigned O_PER_CYC   = O_PERIOD_MS * 1000000 / CLK_NS;
	localparam int unsigned O_DUTY_CYC  = O_ON_CYC * (100 / O_DUTY_PCT);
	localparam int unsigned O_GAP_CYC   = (O_PER_CYC > O_DUTY_CYC ? O_PER_CYC : O_DUTY_CYC)
	                                      - O_ON_CYC - SETTLE_CYC;
	localparam int unsigned I_PULSE_CYC = I_PULSE_MS * 1000000 / CLK_NS;
	localparam int unsigned I_OFF_CYC   = I_OFF_MS * 1000000 / CLK_NS;

	localparam int unsigned TMR_W       = 32;
	localparam logic [2:0]  O_PULSES_L  = 3'h5;
	localparam logic [5:0]  I_PASSES_L  = 6'h20;

	typedef enum logic [3:0] {
		EPS_IDLE, EPS_SETTLE, EPS_LEAD, EPS_TRUE, EPS_PROG, EPS_LAG, EPS_OFF,
		EPS_VADDR, EPS_VCHK, EPS_DONE
	} eps_state_t;

endpackage

// file: rtl/eps_sequencer.sv
// Host-side programming sequencer for a 2048-bit floating-gate field-programmable ROM.
// Holds a 256 x 8 image, drives address, data, pulsed supplies and program lead as
// logic levels (1 = negative programming level), then reads back and compares.
// Assumes external level shifters turn each logic output into the programming voltages.
// Functional notes
// - Original variant: address zero is a strongly negative level, address one about 0 V; the address is driven true, so a one bit is the negative level.
// - Original variant: data lead at 0 V leaves the bit low, negative level makes it high.
// - Address goes on the address leads, data on the output leads, and supplies pulse.
// - Supply and program pulses wait until address and data have settled.
// - Original variant: supplies lead the program pulse by 1 us and trail it by 1 us.
// - Original variant: pulse duty cycle stays at or below two percent.
// - Original variant: five 20 ms pulses per word, one second apart.
// - Improved variant: the complement address is driven before supplies turn on.
// - Improved variant: true address comes no sooner than 25 us after supplies on.
// - Improved variant: 3 ms pulse starts 10 us after true address and 100 us after power.
// - Data is held on the data leads for the whole time the drain supply is pulsed.
// - Improved variant: supplies go off 10 to 100 us after the program pulse ends.
// - Improved variant: all addresses are stepped in ascending order 32 times with identical pulses.
// - Improved variant: applied power duty cycle stays at or below twenty percent.
module eps_sequencer
	import eps_pkg::*;
#(
	parameter int unsigned O_PULSE_CYCLES = O_PULSE_CYC,
	parameter int unsigned O_GAP_CYCLES   = O_GAP_CYC,
	parameter int unsigned I_PULSE_CYCLES = I_PULSE_CYC,
	parameter int unsigned I_OFF_CYCLES   = I_OFF_CYC
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	// Image load and control
	input  wire logic              img_wr_i,
	input  wire logic [ADDR_W-1:0] img_addr_i,
	input  wire logic [DATA_W-1:0] img_data_i,
	input  wire logic              improved_i,
	input  wire logic              start_i,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   fail_o,
	output logic [ADDR_W-1:0]      fail_addr_o,
	// ROM pins, logic level 1 = negative programming level
	output logic [ADDR_W-1:0]      rom_addr_o,
	input  wire logic [DATA_W-1:0] rom_data_i,
	output logic [DATA_W-1:0]      rom_data_o,
	output logic                   rom_data_oe_o,
	output logic                   drain_supply_pulse_o,
	output logic                   gate_supply_pulse_o,
	output logic                   prog_pulse_o
);

	// ---------------------------------------------------------------
	// Image memory
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] img_mem [WORDS];

	// Image write port, usable while idle
	always_ff @(posedge sys_clk_i) begin
		if (img_wr_i) begin
			img_mem[img_addr_i] <= img_data_i;
		end
	end

	// ---------------------------------------------------------------
	// Read-back synchroniser
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] rd_meta_r;
	logic [DATA_W-1:0] rd_sync_r;

	// Two flops before any compare looks at the pins
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_meta_r <= '0;
			rd_sync_r <= '0;
		end else begin
			rd_meta_r <= rom_data_i;
			rd_sync_r <= rd_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer state
	// ---------------------------------------------------------------
	eps_state_t        st_r,      st_nxt;
	logic [TMR_W-1:0]  tmr_r,     tmr_nxt;
	logic [ADDR_W-1:0] word_r,    word_nxt;
	logic [2:0]        pulse_r,   pulse_nxt;
	logic [5:0]        pass_r,    pass_nxt;
	logic              impr_r,    impr_nxt;
	logic [ADDR_W-1:0] addr_r,    addr_nxt;
	logic [DATA_W-1:0] data_r,    data_nxt;
	logic              oe_r,      oe_nxt;
	logic              drain_r,   drain_nxt;
	logic              gate_r,    gate_nxt;
	logic              prog_r,    prog_nxt;
	logic              busy_r,    busy_nxt;
	logic              done_r,    done_nxt;
	logic              fail_r,    fail_nxt;
	logic [ADDR_W-1:0] faddr_r,   faddr_nxt;
	logic              tmr_zero;
	logic              last_word;

	// Cycle count as a timer load value
	function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
		return TMR_W'(n - 1);
	endfunction

	assign tmr_zero  = (tmr_r == '0);
	assign last_word = (word_r == ADDR_W'(WORDS - 1));

	// Next-state and pin values
	always_comb begin
		st_nxt    = st_r;
		tmr_nxt   = tmr_zero ? tmr_r : tmr_r - TMR_W'(1);
		word_nxt  = word_r;
		pulse_nxt = pulse_r;
		pass_nxt  = pass_r;
		impr_nxt  = impr_r;
		addr_nxt  = addr_r;
		data_nxt  = data_r;
		oe_nxt    = oe_r;
		drain_nxt = drain_r;
		gate_nxt  = gate_r;
		prog_nxt  = prog_r;
		busy_nxt  = busy_r;
		done_nxt  = done_r;
		fail_nxt  = fail_r;
		faddr_nxt = faddr_r;
		unique case (st_r)
			EPS_IDLE: begin
				if (start_i) begin
					impr_nxt  = improved_i;
					word_nxt  = '0;
					pulse_nxt = '0;
					pass_nxt  = '0;
					busy_nxt  = 1'b1;
					done_nxt  = 1'b0;
					fail_nxt  = 1'b0;
					faddr_nxt = '0;
					st_nxt    = EPS_SETTLE;
					// Present address (complement in improved mode) and data first
					addr_nxt  = improved_i ? ~ADDR_W'(0) : '0;
					data_nxt  = img_mem['0];
					oe_nxt    = 1'b1;
					tmr_nxt   = cyc(SETTLE_CYC);
				end
			end
			EPS_SETTLE: begin
				// Supplies only after levels settle
				if (tmr_zero) begin
					drain_nxt = 1'b1;
					gate_nxt  = 1'b1;
					st_nxt    = impr_r ? EPS_TRUE : EPS_LEAD;
					tmr_nxt   = impr_r ? cyc(I_COMP_CYC) : cyc(O_LEAD_CYC);
				end
			end
			EPS_TRUE: begin
				// Return address to true form, then wait out the 100 us power time
				if (tmr_zero) begin
					addr_nxt = word_r;
					st_nxt   = EPS_LEAD;
					tmr_nxt  = cyc(I_REST_CYC > I_TRUE_CYC ? I_REST_CYC : I_TRUE_CYC);
				end
			end
			EPS_LEAD: begin
				if (tmr_zero) begin
					prog_nxt = 1'b1;
					st_nxt   = EPS_PROG;
					tmr_nxt  = impr_r ? cyc(I_PULSE_CYCLES) : cyc(O_PULSE_CYCLES);
				end
			end
			EPS_PROG: begin
				if (tmr_zero) begin
					prog_nxt = 1'b0;
					st_nxt   = EPS_LAG;
					tmr_nxt  = impr_r ? cyc(I_LAG_CYC) : cyc(O_LAG_CYC);
				end
			end
			EPS_LAG: begin
				// Data stays driven through the whole drain pulse
				if (tmr_zero) begin
					drain_nxt = 1'b0;
					gate_nxt  = 1'b0;
					st_nxt    = EPS_OFF;
					tmr_nxt   = impr_r ? cyc(I_OFF_CYCLES) : cyc(O_GAP_CYCLES);
				end
			end
			EPS_OFF: begin
				if (tmr_zero) begin
					st_nxt  = EPS_SETTLE;
					tmr_nxt = cyc(SETTLE_CYC);
					if (!impr_r && (pulse_r != O_PULSES_L - 3'h1)) begin
						pulse_nxt = pulse_r + 3'h1;
					end else begin
						pulse_nxt = '0;
						word_nxt  = word_r + ADDR_W'(1);
						if (last_word && (!impr_r || pass_r == I_PASSES_L - 6'h1)) begin
							st_nxt  = EPS_VADDR;
							oe_nxt  = 1'b0;
							tmr_nxt = cyc(READ_CYC);
						end else if (last_word) begin
							pass_nxt = pass_r + 6'h1;
						end
					end
					addr_nxt = impr_r ? ~word_nxt : word_nxt;
					data_nxt = img_mem[word_nxt];
					if (st_nxt == EPS_VADDR) begin
						addr_nxt = '0;
						data_nxt = '0;
					end
				end
			end
			EPS_VADDR: begin
				// Read access wait covers the synchroniser latency
				if (tmr_zero) begin
					st_nxt = EPS_VCHK;
				end
			end
			EPS_VCHK: begin
				// First mismatch is kept
				if (rd_sync_r != img_mem[word_r] && !fail_r) begin
					fail_nxt  = 1'b1;
					faddr_nxt = word_r;
				end
				word_nxt = word_r + ADDR_W'(1);
				addr_nxt = word_nxt;
				tmr_nxt  = cyc(READ_CYC);
				st_nxt   = last_word ? EPS_DONE : EPS_VADDR;
			end
			EPS_DONE: begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				addr_nxt = '0;
				st_nxt   = EPS_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r    <= EPS_IDLE;
			tmr_r   <= '0;
			word_r  <= '0;
			pulse_r <= '0;
			pass_r  <= '0;
			impr_r  <= 1'b0;
			addr_r  <= '0;
			data_r  <= '0;
			oe_r    <= 1'b0;
			drain_r <= 1'b0;
			gate_r  <= 1'b0;
			prog_r  <= 1'b0;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
			fail_r  <= 1'b0;
			faddr_r <= '0;
		end else begin
			st_r    <= st_nxt;
			tmr_r   <= tmr_nxt;
			word_r  <= word_nxt;
			pulse_r <= pulse_nxt;
			pass_r  <= pass_nxt;
			impr_r  <= impr_nxt;
			addr_r  <= addr_nxt;
			data_r  <= data_nxt;
			oe_r    <= oe_nxt;
			drain_r <= drain_nxt;
			gate_r  <= gate_nxt;
			prog_r  <= prog_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
			fail_r  <= fail_nxt;
			faddr_r <= faddr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all from flops
	// ---------------------------------------------------------------
	assign rom_addr_o           = addr_r;
	assign rom_data_o           = data_r;
	assign rom_data_oe_o        = oe_r;
	assign drain_supply_pulse_o = drain_r;
	assign gate_supply_pulse_o  = gate_r;
	assign prog_pulse_o         = prog_r;
	assign busy_o               = busy_r;
	assign done_o               = done_r;
	assign fail_o               = fail_r;
	assign fail_addr_o          = faddr_r;

endmodule // eps_sequencer

// file: verif/eps_checker.sv
// Port checker for the ROM programming sequencer.
// Assumes it is bound to eps_sequencer; improved_i stays fixed during a run.
module eps_checker
	import eps_pkg::*;
#(
	parameter int unsigned O_PULSE_CYCLES = 20,
	parameter int unsigned I_PULSE_CYCLES = 20
) (
	input wire logic              sys_clk_i,
	input wire logic              rst_n_i,
	input wire logic              improved_i,
	input wire logic [ADDR_W-1:0] rom_addr_o,
	input wire logic [DATA_W-1:0] rom_data_o,
	input wire logic              rom_data_oe_o,
	input wire logic              drain_supply_pulse_o,
	input wire logic              gate_supply_pulse_o,
	input wire logic              prog_pulse_o
);
	logic [15:0]       on_r;
	logic [15:0]       stb_r;
	logic [15:0]       pw_r;
	logic [ADDR_W-1:0] last_r;
	logic [ADDR_W-1:0] comp_r;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Supply-on, address-stable and pulse-width counters
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			on_r <= 16'h0;
			stb_r <= 16'h0;
			pw_r <= 16'h0;
			last_r <= 8'h00;
			comp_r <= 8'h00;
		end else begin
			on_r <= drain_supply_pulse_o ? on_r + 16'h1 : 16'h0;
			stb_r <= (rom_addr_o != last_r) ? 16'h0 : stb_r + {15'h0, ~&stb_r};
			pw_r <= prog_pulse_o ? pw_r + 16'h1 : 16'h0;
			last_r <= rom_addr_o;
			if (!drain_supply_pulse_o)
				comp_r <= rom_addr_o; // Address held before power is the complement in improved mode
		end
	end
	sequence s_imp_off;
		##[499:1000] $fell(drain_supply_pulse_o);
	endsequence
	a_prog_needs_power: assert property (prog_pulse_o |-> drain_supply_pulse_o && gate_supply_pulse_o)
		else $error("program pulse without both supplies");
	a_orig_lead: assert property (!improved_i && $rose(prog_pulse_o) |-> on_r inside {[48:52]})
		else $error("supply lead before pulse wrong");
	a_orig_lag: assert property (!improved_i && $fell(prog_pulse_o) |-> ##[47:53] $fell(drain_supply_pulse_o))
		else $error("supply lag after pulse wrong");
	a_imp_lag: assert property (improved_i && $fell(prog_pulse_o) |-> s_imp_off)
		else $error("supplies off outside window");
	a_true_addr: assert property (improved_i && drain_supply_pulse_o && $changed(rom_addr_o) |-> on_r >= 16'd1249 && rom_addr_o == ~comp_r)
		else $error("true address too early or wrong");
	a_imp_prog_start: assert property (improved_i && $rose(prog_pulse_o) |-> on_r >= 16'd4998 && stb_r >= 16'd499)
		else $error("program pulse too early");
	a_power_settled: assert property ($rose(drain_supply_pulse_o) |-> stb_r >= 16'd45 && rom_data_oe_o)
		else $error("supplies before leads settled");
	a_data_held: assert property (drain_supply_pulse_o |-> rom_data_oe_o && $stable(rom_data_o))
		else $error("data moved under supply");
	a_pulse_width: assert property ($fell(prog_pulse_o) |-> pw_r + 1 >= (improved_i ? I_PULSE_CYCLES : O_PULSE_CYCLES) && pw_r <= (improved_i ? I_PULSE_CYCLES : O_PULSE_CYCLES) + 1)
		else $error("program pulse width wrong");
endmodule // eps_checker

bind eps_sequencer eps_checker #(.O_PULSE_CYCLES(O_PULSE_CYCLES), .I_PULSE_CYCLES(I_PULSE_CYCLES))
	i_eps_checker (.sys_clk_i, .rst_n_i, .improved_i, .rom_addr_o, .rom_data_o, .rom_data_oe_o,
	.drain_supply_pulse_o, .gate_supply_pulse_o, .prog_pulse_o);

// file: verif/eps_rom_model.sv
// Behavioural field-programmable ROM seen from its pins.
// Assumes logic 1 on data and supply pins stands for the negative level.
module eps_rom_model
	import eps_pkg::*;
(
	input  wire logic              improved_i,
	input  wire logic              erase_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] data_i,
	input  wire logic              data_oe_i,
	input  wire logic              drain_i,
	input  wire logic              gate_i,
	input  wire logic              prog_i,
	output logic      [DATA_W-1:0] rd_o
);
	logic [DATA_W-1:0] mem [WORDS];
	// Erase sets every cell to the blank value of the variant
	always @(posedge erase_i) begin
		for (int i = 0; i < WORDS; i++)
			mem[i] = {DATA_W{~improved_i}};
	end
	// A pulse under both supplies with data driven moves bits one way only
	always @(posedge prog_i) begin
		if (drain_i && gate_i && data_oe_i) begin
			if (improved_i)
				mem[addr_i] = mem[addr_i] | data_i;
			else
				mem[addr_i] = mem[addr_i] & data_i;
		end
	end
	// Driven leads show the programmer's level, else the stored word
	assign rd_o = data_oe_i ? data_i : mem[addr_i];
endmodule // eps_rom_model

// file: verif/test_eps_sequencer.sv
// Self-checking bench for the ROM programming sequencer.
// Assumes shortened pulse and gap counts; runs the first word of each variant.
module test_eps_sequencer import eps_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic              sys_clk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	logic              img_wr_i = 1'b0;
	logic              improved_i = 1'b0;
	logic              start_i = 1'b0;
	logic              erase = 1'b0;
	logic [ADDR_W-1:0] img_addr_i = 8'h00;
	logic [DATA_W-1:0] img_data_i = 8'h00;
	logic [ADDR_W-1:0] rom_addr_o, fail_addr_o;
	logic [DATA_W-1:0] rom_data_i, rom_data_o;
	logic              busy_o, done_o, fail_o, rom_data_oe_o;
	logic              drain_supply_pulse_o, gate_supply_pulse_o, prog_pulse_o;
	int                n_errors = 0;
	int                checked = 0;
	int                cyc = 0;
	always #10 sys_clk_i = ~sys_clk_i;
	eps_sequencer #(.O_PULSE_CYCLES(20), .O_GAP_CYCLES(30), .I_PULSE_CYCLES(20), .I_OFF_CYCLES(30))
		i_eps_sequencer (.sys_clk_i, .rst_n_i, .img_wr_i, .img_addr_i, .img_data_i, .improved_i,
		.start_i, .busy_o, .done_o, .fail_o, .fail_addr_o, .rom_addr_o, .rom_data_i, .rom_data_o,
		.rom_data_oe_o, .drain_supply_pulse_o, .gate_supply_pulse_o, .prog_pulse_o);
	eps_rom_model i_eps_rom_model (.improved_i, .erase_i(erase), .addr_i(rom_addr_o),
		.data_i(rom_data_o), .data_oe_i(rom_data_oe_o), .drain_i(drain_supply_pulse_o),
		.gate_i(gate_supply_pulse_o), .prog_i(prog_pulse_o), .rd_o(rom_data_i));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tick;
		@(posedge sys_clk_i);
		#1;
	endtask
	// Reset, also in mid-run, clears every output and erases the part
	task automatic do_reset(input logic imp);
		rst_n_i = 1'b0;
		improved_i = imp;
		// Erase edge comes one cycle late so the model is surely waiting for it
		tick();
		erase = 1'b1;
		repeat (4) tick();
		check("outputs in reset", {busy_o, done_o, fail_o, rom_data_oe_o, drain_supply_pulse_o,
			gate_supply_pulse_o, prog_pulse_o, 1'b0}, 8'h00);
		check("address in reset", rom_addr_o, 8'h00);
		rst_n_i = 1'b1;
		erase = 1'b0;
	endtask
	// Program word 0 and follow the sequencer onto the next address
	task automatic run_word(input logic imp, input int pulses, input logic [7:0] nxt);
		int n = 0;
		logic p = 1'b0;
		start_i = 1'b1;
		tick();
		start_i = 1'b0;
		tick();
		check("busy", {7'h0, busy_o}, 8'h01);
		check("first address", rom_addr_o, imp ? 8'hff : 8'h00);
		check("run flags", {6'h00, done_o, fail_o}, 8'h00);
		check("fail address", fail_addr_o, 8'h00);
		for (int i = 0; i < 8000 && rom_addr_o !== nxt; i++) begin
			if (prog_pulse_o && !p)
				n++;
			p = prog_pulse_o;
			tick();
		end
		check("next address", rom_addr_o, nxt);
		check("pulses per word", 8'(n), 8'(pulses));
		check("word 0", i_eps_rom_model.mem[0], 8'h5a);
		check("word 1 blank", i_eps_rom_model.mem[1], imp ? 8'h00 : 8'hff);
	endtask
	// Timeout guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		do_reset(1'b0);
		img_wr_i = 1'b1;
		for (int a = 0; a < WORDS; a++) begin
			img_addr_i = 8'(a);
			img_data_i = 8'(a) ^ 8'h5a;
			tick();
		end
		img_wr_i = 1'b0;
		run_word(1'b0, 5, 8'h01);
		do_reset(1'b1);
		run_word(1'b1, 1, 8'hfe);
		give_verdict();
	end
endmodule // test_eps_sequencer
